// file: common/ppil_map.svh
`ifndef PPIL_MAP_SVH
`define PPIL_MAP_SVH

// ----------------------------------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------------------------------
`define PPIL_OFF_PA_DATA 6'h00
`define PPIL_OFF_PB_DATA 6'h04
`define PPIL_OFF_PC_DATA 6'h08
`define PPIL_OFF_PD_DATA 6'h0C
`define PPIL_OFF_PA_DIR 6'h10
`define PPIL_OFF_PB_DIR 6'h14
`define PPIL_OFF_PC_DIR 6'h18
`define PPIL_OFF_PE_DATA 6'h1C
`define PPIL_OFF_PF_DATA 6'h20
`define PPIL_OFF_PF_DIR 6'h24
`define PPIL_OFF_ADC_CTRL 6'h28
`define PPIL_OFF_SYS_CTRL 6'h2C
`define PPIL_OFF_MISC 6'h30
`define PPIL_OFF_IRQ_CTRL 6'h34
// Address bits at and above this one must be zero
`define PPIL_DEC_TOP 6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPIL_ADC_EN_BIT 7
`define PPIL_SYS_SPI_EN_BIT 0
`define PPIL_SYS_STOP_BIT 1
`define PPIL_SYS_CMP_EN_BIT 2
`define PPIL_MISC_IGN_BIT 0
`define PPIL_MISC_PWRDN_BIT 1
`define PPIL_MISC_IGN_WAKE_BIT 2
`define PPIL_MISC_BUS_WAKE_BIT 3
`define PPIL_IRQ_EN_BIT 0
`define PPIL_IRQ_PEND_BIT 1
`define PPIL_PB_CMP_BIT 6
`define PPIL_PB_CAP_BIT 7

// ----------------------------------------------------------------
// Reset values and synchroniser layout
// ----------------------------------------------------------------
`define PPIL_PORT_RST 8'h00
`define PPIL_NIB_RST 4'h0
`define PPIL_SYNC_W 48
// Interrupt pin and reset pin idle high
`define PPIL_SYNC_INIT 48'h0000_0000_0003

`endif

// file: common/ppil_pkg.sv
package ppil_pkg;

    typedef logic [7:0] ppil_byte_t;

    typedef struct packed {
        logic [7:0] pa_lat;
        logic [7:0] pa_dir;
        logic [7:0] pb_lat;
        logic [7:0] pb_dir;
        logic [7:0] pc_lat;
        logic [7:0] pc_dir;
        logic [3:0] pf_lat;
        logic [3:0] pf_dir;
        logic adc_en;
        logic [3:0] adc_ch;
        logic spi_en;
        logic stop;
        logic cmp_en;
        logic irq_en;
        logic pend;
        logic reg_down;
        logic ign_wake;
        logic bus_wake;
        logic drive;
        logic core_rst;
        logic op_clk;
        logic irq_prev;
        logic [7:0] pa_prev;
        logic [7:0] pc_prev;
        logic ign_prev;
        logic bus_prev;
        logic [31:0] rdata;
    } ppil_state_t;

endpackage

// file: rtl/ppil_sync.sv
`timescale 1ns/100ps
module ppil_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ppil_sync_t;

    ppil_sync_t st_r;
    ppil_sync_t st_nxt;

    initial begin
        if (WIDTH < 1) begin
            $error("ppil_sync: WIDTH must be at least 1");
        end
    end

    // First stage feeds only the second stage
    always_comb begin
        st_nxt.meta = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= {INIT, INIT};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

endmodule

// file: rtl/ppil_top.sv
`timescale 1ns/100ps
`include "ppil_map.svh"
// Contract
// RULE_01: Oscillator output is inverted oscillator input, forced high in stop.
// RULE_02: Operating clock is the oscillator clock divided by two.
// RULE_03: Reset pin held low externally resets the device to start-up state.
// RULE_04: Device pulls reset pin low on any internal reset source.
// RULE_05: Option selects interrupt pin falling edge only, or edge plus low level.
// RULE_06: Port A, port C and interrupt pin are ORed into one request.
// RULE_07: Port A and C interrupts are always falling-edge triggered.
// RULE_08: Port A and C act as interrupt sources only while enabled.
// RULE_09: Any reset makes every pin of ports A, B, C, F an input.
// RULE_10: Port B pins carry timer capture input and compare output.
// RULE_11: Converter disabled after reset; ports D, E then digital inputs.
// RULE_12: With converter on, selected channel reads zero, others read true.
// RULE_13: Serial port enabled takes over the four port F pins.
// RULE_14: Ignition pin level is readable as a status bit.
// RULE_15: Ignition rising edge while regulator down is latched, powers it up.
// RULE_16: With bus wake option, bus line rising edge re-enables regulator.
// RULE_17: With regulator disabled by option, ignition pin has no function.
// RULE_18: All registers decode within byte addresses 0x00 to 0x3F.
// RULE_19: Writes to unimplemented bits are ignored; their reads are undefined.
// RULE_20: Board holds an unused interrupt pin at high supply.
// RULE_21: Detected interrupt edges stay pending until the CPU services them.
// RULE_22: Asynchronous pins pass a two-stage synchroniser before edge detection.
module ppil_top #(
    parameter int ADDR_W = 12,
    parameter int ADC_CHANNELS = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Factory options
    input wire logic opt_irq_level,
    input wire logic opt_bus_wake,
    input wire logic opt_reg_disable,
    // Oscillator and operating clock
    input wire logic oscillator_input_pin,
    output logic oscillator_output_pin,
    output logic operating_frequency_clk,
    // Reset pin (open drain) and reset sources
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic watchdog_timer_timeout,
    input wire logic power_on_detect,
    input wire logic illegal_address,
    input wire logic stop_disabled_exec,
    input wire logic low_voltage_detect,
    output logic core_reset,
    // Interrupt pin and request to the CPU
    input wire logic irq_pin_in,
    input wire logic irq_ack,
    output logic irq_request,
    // Ports A, B, C
    input wire logic [7:0] port_a_pins_in,
    output logic [7:0] port_a_pins_out,
    output logic [7:0] port_a_pins_oe,
    input wire logic [7:0] port_b_pins_in,
    output logic [7:0] port_b_pins_out,
    output logic [7:0] port_b_pins_oe,
    input wire logic [7:0] port_c_pins_in,
    output logic [7:0] port_c_pins_out,
    output logic [7:0] port_c_pins_oe,
    // Timer sharing on port B
    input wire logic compare_output_level,
    output logic capture_input_pin,
    // Ports D, E (input only, converter shared)
    input wire logic [7:0] port_d_inputs,
    input wire logic [7:0] port_e_inputs,
    output logic adc_enable,
    output logic [3:0] adc_channel,
    // Port F and serial peripheral port
    input wire logic [3:0] port_f_pins_in,
    output logic [3:0] port_f_pins_out,
    output logic [3:0] port_f_pins_oe,
    input wire logic [3:0] spi_pins_out,
    input wire logic [3:0] spi_pins_oe,
    output logic [3:0] spi_pins_in,
    output logic spi_enable,
    // Regulator power moding
    input wire logic ignition_sense_pin,
    input wire logic message_link_bus_pin,
    output logic regulator_enable
);

    initial begin
        if (ADDR_W < `PPIL_DEC_TOP + 1) begin
            $error("ppil_top: ADDR_W too small for the register map");
        end
        if (ADC_CHANNELS != 16) begin
            $error("ppil_top: ADC_CHANNELS must be 16 (ports D and E)");
        end
    end

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    logic [`PPIL_SYNC_W-1:0] sync_q;
    logic irq_s;
    logic rst_pin_s;
    logic [7:0] pa_s;
    logic [7:0] pb_s;
    logic [7:0] pc_s;
    logic [7:0] pd_s;
    logic [7:0] pe_s;
    logic [3:0] pf_s;
    logic ign_s;
    logic bus_s;

    ppil_sync #(
        .WIDTH(`PPIL_SYNC_W),
        .INIT(`PPIL_SYNC_INIT)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({message_link_bus_pin, ignition_sense_pin, port_f_pins_in,
                   port_e_inputs, port_d_inputs, port_c_pins_in,
                   port_b_pins_in, port_a_pins_in, reset_pin_in,
                   irq_pin_in}),
        .sync_out(sync_q)
    ); // see RULE_22

    assign {bus_s, ign_s, pf_s, pe_s, pd_s, pc_s, pb_s, pa_s, rst_pin_s,
            irq_s} = sync_q;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    ppil_pkg::ppil_state_t st_r;
    ppil_pkg::ppil_state_t st_nxt;

    function automatic ppil_pkg::ppil_state_t reset_state();
        ppil_pkg::ppil_state_t s;
        s = '0;
        s.drive = 1'b1;
        s.core_rst = 1'b1;
        s.irq_prev = 1'b1;
        return s;
    endfunction

    // Outputs read back the latch, inputs the pin
    function automatic ppil_pkg::ppil_byte_t port_read(
        input logic [7:0] lat,
        input logic [7:0] dir,
        input logic [7:0] pin
    );
        return (dir & lat) | (~dir & pin);
    endfunction

    // Mask of the pin given to the converter within one 8-pin port
    function automatic ppil_pkg::ppil_byte_t adc_mask(
        input logic en,
        input logic [3:0] ch,
        input logic upper
    );
        ppil_pkg::ppil_byte_t m;
        m = 8'h00;
        if (en && (ch[3] == upper)) begin
            m[ch[2:0]] = 1'b1;
        end
        return m;
    endfunction

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic in_range;
    logic wr_en;
    logic [5:0] woff;
    logic [7:0] wbyte;
    logic [7:0] rd_val;
    logic irq_fall;
    logic irq_low;
    logic port_fall;
    logic ign_rise;
    logic bus_rise;
    logic pend_set;
    logic pend_clr;

    assign in_range = (paddr[ADDR_W-1:`PPIL_DEC_TOP] == '0); // see RULE_18
    assign wr_en = psel && penable && pwrite && in_range && pstrb[0];
    assign woff = paddr[5:0];
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !in_range;

    always_comb begin
        rd_val = 8'h00;
        case (paddr[5:0])
            `PPIL_OFF_PA_DATA: begin
                rd_val = port_read(st_r.pa_lat, st_r.pa_dir, pa_s);
            end
            `PPIL_OFF_PB_DATA: begin
                rd_val = port_read(st_r.pb_lat, st_r.pb_dir, pb_s);
            end
            `PPIL_OFF_PC_DATA: begin
                rd_val = port_read(st_r.pc_lat, st_r.pc_dir, pc_s);
            end
            `PPIL_OFF_PD_DATA: begin
                rd_val = pd_s & ~adc_mask(st_r.adc_en, st_r.adc_ch, 1'b0); // see RULE_12
            end
            `PPIL_OFF_PE_DATA: begin
                rd_val = pe_s & ~adc_mask(st_r.adc_en, st_r.adc_ch, 1'b1); // see RULE_12
            end
            `PPIL_OFF_PA_DIR: begin
                rd_val = st_r.pa_dir;
            end
            `PPIL_OFF_PB_DIR: begin
                rd_val = st_r.pb_dir;
            end
            `PPIL_OFF_PC_DIR: begin
                rd_val = st_r.pc_dir;
            end
            `PPIL_OFF_PF_DATA: begin
                // Serial port owns the pins: read their levels
                rd_val = st_r.spi_en ? {4'h0, pf_s} : port_read(
                    {4'h0, st_r.pf_lat}, {4'h0, st_r.pf_dir}, {4'h0, pf_s});
            end
            `PPIL_OFF_PF_DIR: begin
                rd_val = {4'h0, st_r.pf_dir};
            end
            `PPIL_OFF_ADC_CTRL: begin
                rd_val[`PPIL_ADC_EN_BIT] = st_r.adc_en;
                rd_val[3:0] = st_r.adc_ch;
            end
            `PPIL_OFF_SYS_CTRL: begin
                rd_val[`PPIL_SYS_SPI_EN_BIT] = st_r.spi_en;
                rd_val[`PPIL_SYS_STOP_BIT] = st_r.stop;
                rd_val[`PPIL_SYS_CMP_EN_BIT] = st_r.cmp_en;
            end
            `PPIL_OFF_MISC: begin
                rd_val[`PPIL_MISC_IGN_BIT] = ign_s && !opt_reg_disable; // see RULE_14 RULE_17
                rd_val[`PPIL_MISC_PWRDN_BIT] = st_r.reg_down;
                rd_val[`PPIL_MISC_IGN_WAKE_BIT] = st_r.ign_wake;
                rd_val[`PPIL_MISC_BUS_WAKE_BIT] = st_r.bus_wake;
            end
            `PPIL_OFF_IRQ_CTRL: begin
                rd_val[`PPIL_IRQ_EN_BIT] = st_r.irq_en;
                rd_val[`PPIL_IRQ_PEND_BIT] = st_r.pend;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    assign irq_fall = st_r.irq_prev && !irq_s;
    assign irq_low = opt_irq_level && !irq_s; // see RULE_05
    // Port sources ignore the level option
    assign port_fall = st_r.irq_en &&
        (|(st_r.pa_prev & ~pa_s) || |(st_r.pc_prev & ~pc_s)); // see RULE_07 RULE_08
    assign pend_set = irq_fall || irq_low || port_fall; // see RULE_06
    assign pend_clr = irq_ack || (wr_en && woff == `PPIL_OFF_IRQ_CTRL &&
        wbyte[`PPIL_IRQ_PEND_BIT]);
    assign ign_rise = !st_r.ign_prev && ign_s && !opt_reg_disable; // see RULE_17
    assign bus_rise = !st_r.bus_prev && bus_s && opt_bus_wake; // see RULE_16

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.op_clk = !st_r.op_clk; // see RULE_02
        st_nxt.drive = watchdog_timer_timeout || power_on_detect ||
            illegal_address || stop_disabled_exec ||
            low_voltage_detect; // see RULE_04
        st_nxt.core_rst = !rst_pin_s || st_r.drive; // see RULE_03
        st_nxt.irq_prev = irq_s;
        st_nxt.pa_prev = pa_s;
        st_nxt.pc_prev = pc_s;
        st_nxt.ign_prev = ign_s;
        st_nxt.bus_prev = bus_s;
        // Set wins over clear so no edge is lost
        if (pend_clr) begin
            st_nxt.pend = 1'b0;
        end
        if (pend_set) begin
            st_nxt.pend = 1'b1; // see RULE_21
        end
        if (wr_en) begin
            case (woff)
                `PPIL_OFF_PA_DATA: st_nxt.pa_lat = wbyte;
                `PPIL_OFF_PB_DATA: st_nxt.pb_lat = wbyte;
                `PPIL_OFF_PC_DATA: st_nxt.pc_lat = wbyte;
                `PPIL_OFF_PA_DIR: st_nxt.pa_dir = wbyte;
                `PPIL_OFF_PB_DIR: st_nxt.pb_dir = wbyte;
                `PPIL_OFF_PC_DIR: st_nxt.pc_dir = wbyte;
                `PPIL_OFF_PF_DATA: st_nxt.pf_lat = wbyte[3:0];
                `PPIL_OFF_PF_DIR: st_nxt.pf_dir = wbyte[3:0];
                `PPIL_OFF_ADC_CTRL: begin
                    st_nxt.adc_en = wbyte[`PPIL_ADC_EN_BIT];
                    st_nxt.adc_ch = wbyte[3:0];
                end
                `PPIL_OFF_SYS_CTRL: begin
                    st_nxt.spi_en = wbyte[`PPIL_SYS_SPI_EN_BIT];
                    st_nxt.stop = wbyte[`PPIL_SYS_STOP_BIT];
                    st_nxt.cmp_en = wbyte[`PPIL_SYS_CMP_EN_BIT];
                end
                `PPIL_OFF_MISC: begin
                    if (wbyte[`PPIL_MISC_PWRDN_BIT]) begin
                        st_nxt.reg_down = 1'b1;
                    end
                    if (wbyte[`PPIL_MISC_IGN_WAKE_BIT]) begin
                        st_nxt.ign_wake = 1'b0;
                    end
                    if (wbyte[`PPIL_MISC_BUS_WAKE_BIT]) begin
                        st_nxt.bus_wake = 1'b0;
                    end
                end
                `PPIL_OFF_IRQ_CTRL: st_nxt.irq_en = wbyte[`PPIL_IRQ_EN_BIT];
                default: st_nxt.pa_lat = st_nxt.pa_lat; // see RULE_19
            endcase
        end
        // Wake latches live in always-on logic; set beats clear
        if (st_r.reg_down && ign_rise) begin
            st_nxt.ign_wake = 1'b1; // see RULE_15
            st_nxt.reg_down = 1'b0;
        end
        if (st_r.reg_down && bus_rise) begin
            st_nxt.bus_wake = 1'b1; // see RULE_16
            st_nxt.reg_down = 1'b0;
        end
        // Pin reset clears the core state, not the always-on state
        if (!rst_pin_s) begin
            st_nxt.pa_lat = `PPIL_PORT_RST;
            st_nxt.pa_dir = `PPIL_PORT_RST; // see RULE_09
            st_nxt.pb_lat = `PPIL_PORT_RST;
            st_nxt.pb_dir = `PPIL_PORT_RST;
            st_nxt.pc_lat = `PPIL_PORT_RST;
            st_nxt.pc_dir = `PPIL_PORT_RST;
            st_nxt.pf_lat = `PPIL_NIB_RST;
            st_nxt.pf_dir = `PPIL_NIB_RST;
            st_nxt.adc_en = 1'b0; // see RULE_11
            st_nxt.adc_ch = `PPIL_NIB_RST;
            st_nxt.spi_en = 1'b0;
            st_nxt.stop = 1'b0;
            st_nxt.cmp_en = 1'b0;
            st_nxt.irq_en = 1'b0;
            st_nxt.pend = 1'b0;
        end
        // Read data is sampled in the setup phase
        if (psel && !penable && !pwrite) begin
            st_nxt.rdata = in_range ? {24'h00_0000, rd_val} : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= reset_state();
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Analog feedback path: a register here would break the oscillator
    assign oscillator_output_pin = st_r.stop ? 1'b1 : !oscillator_input_pin; // see RULE_01
    assign operating_frequency_clk = st_r.op_clk;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = st_r.drive;
    assign core_reset = st_r.core_rst;
    assign irq_request = st_r.pend;
    assign prdata = st_r.rdata;
    assign port_a_pins_out = st_r.pa_lat;
    assign port_a_pins_oe = st_r.pa_dir;
    assign port_b_pins_out = {st_r.pb_lat[7],
        st_r.cmp_en ? compare_output_level : st_r.pb_lat[6],
        st_r.pb_lat[5:0]}; // see RULE_10
    assign port_b_pins_oe = st_r.pb_dir |
        {1'b0, st_r.cmp_en, 6'b00_0000};
    assign capture_input_pin = pb_s[`PPIL_PB_CAP_BIT]; // see RULE_10
    assign port_c_pins_out = st_r.pc_lat;
    assign port_c_pins_oe = st_r.pc_dir;
    assign adc_enable = st_r.adc_en;
    assign adc_channel = st_r.adc_ch;
    assign port_f_pins_out = st_r.spi_en ? spi_pins_out : st_r.pf_lat; // see RULE_13
    assign port_f_pins_oe = st_r.spi_en ? spi_pins_oe : st_r.pf_dir;
    assign spi_pins_in = pf_s;
    assign spi_enable = st_r.spi_en;
    assign regulator_enable = !st_r.reg_down;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_op_rise;
        !operating_frequency_clk ##1 operating_frequency_clk;
    endsequence

    sequence s_op_half;
        !operating_frequency_clk ##1 operating_frequency_clk;
    endsequence

    a_osc_stop_high: assert property (st_r.stop |-> oscillator_output_pin) // see RULE_01
        else $error("oscillator output not high in stop");
    a_op_clk_div: assert property (s_op_rise |=> s_op_half) // see RULE_02
        else $error("operating clock is not half rate");
    a_pin_reset_core: assert property (!rst_pin_s |=> core_reset && // see RULE_03
        port_a_pins_oe == 8'h00 && !adc_enable)
        else $error("pin reset not applied");
    a_reset_pin_drive: assert property (watchdog_timer_timeout || // see RULE_04
        low_voltage_detect |=> reset_pin_oe ##1 core_reset)
        else $error("reset pin not driven for internal reset");
    a_irq_level_set: assert property (opt_irq_level && !irq_s |=> // see RULE_05
        irq_request || !$past(rst_pin_s))
        else $error("level interrupt not pending");
    a_port_edge_set: assert property (st_r.irq_en && // see RULE_07
        |(st_r.pc_prev & ~pc_s) && rst_pin_s |=> irq_request)
        else $error("port falling edge lost");
    a_port_masked: assert property (!st_r.irq_en && !st_r.pend && // see RULE_08
        !irq_fall && !irq_low |=> !irq_request)
        else $error("masked port raised interrupt");
    a_dir_reset_in: assert property ($fell(rst_pin_s) |=> // see RULE_09
        (port_b_pins_oe | port_c_pins_oe) == 8'h00 && port_f_pins_oe == 4'h0)
        else $error("ports not inputs after reset");
    a_ign_wake: assert property (st_r.reg_down && ign_rise |=> // see RULE_15
        regulator_enable && st_r.ign_wake)
        else $error("ignition wake not latched");
    a_unmapped_err: assert property (psel && !penable && !in_range // see RULE_18
        |=> penable |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_pend_hold: assert property (irq_request && !pend_clr && rst_pin_s |=> // see RULE_21
        irq_request)
        else $error("pending request dropped");

endmodule

// file: tb/ppil_board.sv
`timescale 1ns/100ps
module ppil_board (
    // Board controls
    input wire logic ext_rst_n,
    input wire logic irq_low,
    input wire logic reg_disable,
    input wire logic ign_on,
    // Device pins
    input wire logic reset_pin_oe,
    output logic reset_pin_in,
    output logic irq_pin_in,
    output logic ignition_sense_pin
);
    // Open-drain reset line, pulled up on the board
    assign reset_pin_in = ext_rst_n & ~reset_pin_oe;
    // Pulled up unless a test asks for a request
    assign irq_pin_in = ~irq_low;
    // Board ties the ignition pin low without the regulator
    assign ignition_sense_pin = ign_on & ~reg_disable;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_top;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, err, osc_out, irq_req, rpin, rpoe, irqp, ignp;
    logic lvl = 0, bw = 0, rdis = 0, osc = 0, ack = 0, ext_n = 1;
    logic irq_low = 0, ign = 0, bus = 0, reg_en;
    logic [4:0] src = 5'h00;
    logic [7:0] pa = 8'hff, pb = 8'h00, pc = 8'hff, pd = 8'h5a, pe = 8'hff;
    logic [7:0] pa_oe, pb_oe, pc_oe;
    int mismatches = 0, n_tests = 0;
    ppil_board brd_u (.ext_rst_n(ext_n), .irq_low(irq_low),
        .reg_disable(rdis), .ign_on(ign), .reset_pin_oe(rpoe),
        .reset_pin_in(rpin), .irq_pin_in(irqp), .ignition_sense_pin(ignp));
    ppil_top dut_u (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .opt_irq_level(lvl), .opt_bus_wake(bw), .opt_reg_disable(rdis),
        .oscillator_input_pin(osc), .oscillator_output_pin(osc_out),
        .operating_frequency_clk(), .reset_pin_in(rpin), .reset_pin_out(),
        .reset_pin_oe(rpoe), .watchdog_timer_timeout(src[0]),
        .power_on_detect(src[1]), .illegal_address(src[2]),
        .stop_disabled_exec(src[3]), .low_voltage_detect(src[4]),
        .core_reset(), .irq_pin_in(irqp), .irq_ack(ack),
        .irq_request(irq_req), .port_a_pins_in(pa), .port_a_pins_out(),
        .port_a_pins_oe(pa_oe), .port_b_pins_in(pb), .port_b_pins_out(),
        .port_b_pins_oe(pb_oe), .port_c_pins_in(pc), .port_c_pins_out(),
        .port_c_pins_oe(pc_oe), .compare_output_level(1'b0),
        .capture_input_pin(), .port_d_inputs(pd), .port_e_inputs(pe),
        .adc_enable(), .adc_channel(), .port_f_pins_in(4'hf),
        .port_f_pins_out(), .port_f_pins_oe(), .spi_pins_out(4'h0),
        .spi_pins_oe(4'h0), .spi_pins_in(), .spi_enable(),
        .ignition_sense_pin(ignp), .message_link_bus_pin(bus),
        .regulator_enable(reg_en));
    // ----------------------------------------------------------------
    // Bus and wait tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Entered just after a rising edge; holds until pready seen
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int i;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h00_0000, d};
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20) begin
            mismatches++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 10 && irq_req !== 1'b1; i++)
            @(posedge sys_clk);
        if (irq_req !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(pa_oe | pb_oe | pc_oe, 8'h00)
        apb(0, 12'h010, 8'h00);
        `CHK(rd[7:0], 8'h00)
        apb(0, 12'h028, 8'h00);
        `CHK(rd[7], 1'b0)
        apb(0, 12'h00c, 8'h00);
        `CHK(rd[7:0], 8'h5a)
        apb(1, 12'h028, 8'h83);
        apb(0, 12'h00c, 8'h00);
        `CHK(rd[7:0], 8'h52)
        apb(0, 12'h01c, 8'h00);
        `CHK(rd[7:0], 8'hff)
        apb(1, 12'h040, 8'hff);
        `CHK(err, 1'b1)
        apb(0, 12'h040, 8'h00);
        `CHK(rd, 32'h0000_0000)
        $display("test ports and map done");
        apb(1, 12'h034, 8'h01);
        pc <= 8'hfe;
        wait_irq();
        `CHK(irq_req, 1'b1)
        pc <= 8'hff;
        apb(0, 12'h034, 8'h00);
        `CHK(rd[1:0], 2'b11)
        apb(1, 12'h034, 8'h02);
        apb(0, 12'h034, 8'h00);
        `CHK(rd[1:0], 2'b00)
        pa <= 8'h7f;
        repeat (6) @(posedge sys_clk);
        `CHK(irq_req, 1'b0)
        irq_low <= 1'b1;
        wait_irq();
        `CHK(irq_req, 1'b1)
        irq_low <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ack <= 1'b1;
        @(posedge sys_clk);
        ack <= 1'b0;
        @(posedge sys_clk);
        `CHK(irq_req, 1'b0)
        lvl <= 1'b1;
        irq_low <= 1'b1;
        wait_irq();
        ack <= 1'b1;
        @(posedge sys_clk);
        ack <= 1'b0;
        @(posedge sys_clk);
        `CHK(irq_req, 1'b1)
        irq_low <= 1'b0;
        lvl <= 1'b0;
        $display("test interrupts done");
        osc <= 1'b1;
        @(posedge sys_clk);
        `CHK(osc_out, 1'b0)
        apb(1, 12'h02c, 8'h02);
        @(posedge sys_clk);
        `CHK(osc_out, 1'b1)
        src <= 5'h01;
        repeat (2) @(posedge sys_clk);
        `CHK(rpoe, 1'b1)
        src <= 5'h00;
        repeat (8) @(posedge sys_clk);
        apb(1, 12'h010, 8'hff);
        `CHK(pa_oe, 8'hff)
        ext_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        ext_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        `CHK(pa_oe, 8'h00)
        $display("test oscillator and reset done");
        ign <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(0, 12'h030, 8'h00);
        `CHK(rd[0], 1'b1)
        apb(1, 12'h030, 8'h02);
        `CHK(reg_en, 1'b0)
        ign <= 1'b0;
        repeat (3) @(posedge sys_clk);
        ign <= 1'b1;
        repeat (5) @(posedge sys_clk);
        `CHK(reg_en, 1'b1)
        apb(0, 12'h030, 8'h00);
        `CHK(rd[3:1], 3'b010)
        bw <= 1'b1;
        apb(1, 12'h030, 8'h06);
        bus <= 1'b1;
        repeat (5) @(posedge sys_clk);
        apb(0, 12'h030, 8'h00);
        `CHK(rd[3:1], 3'b100)
        $display("test regulator done");
        report_and_stop();
    end
endmodule
